/* src/fspm_map.vh */
// Purpose: constants for the five state power manager
// Assumes: ref_clk at 100 MHz, AHB-Lite register port
// Notes: byte addresses of the register words, state codes, timing constants
//
// Functional notes
// - system is always in exactly one of run, slow, idle, sleep, deep sleep.
// - run keeps all clocks on and SDRAM in normal refresh; in run the code drives periph_clk_en from the gate register.
// - slow puts the CPU in bus-rate clocking, half the fast clock.
// - after power-on the system goes to slow; after deep sleep exit it idles at bus-rate clocking.
// - entering idle takes bus mastership until a fast or normal interrupt.
// - in idle the CPU clock stops when the CPU tries a bus access.
// - writing 0x2 to mode bits [2:0] in run or slow enters idle.
// - a wake-up in sleep or deep sleep moves the system to idle.
// - sleep puts SDRAM in self-refresh and gates internal clocks off.
// - sleep is entered only from idle while the bus is already owned.
// - sleep may proceed onward into deep sleep.
// - deep sleep disables the main oscillator and both PLLs.
// - deep sleep runs only the RTC clock; debounce ticks at RTC divided by 8.
// - deep sleep powers down all but RTC and debounce; SDRAM stays self-refresh.
// - on-key, RTC alarm or modem ring may each end sleep or deep sleep.
// - return from standby releases self-refresh only once clocks are back.
// - per-peripheral clock gates let idle peripherals be stopped one by one.
// - the ring wake source is the ring input of the modem serial port.
`ifndef FSPM_MAP_VH
`define FSPM_MAP_VH

`define FSPM_ADDR_MODE 8'h00
`define FSPM_ADDR_GATE 8'h04
`define FSPM_ADDR_STAT 8'h08

`define FSPM_MODE_RUN 3'h0
`define FSPM_MODE_SLOW 3'h1
`define FSPM_MODE_IDLE 3'h2
`define FSPM_MODE_SLEEP 3'h3
`define FSPM_MODE_DEEP 3'h4

`define FSPM_GATE_RESET 16'hFFFF
`define FSPM_RTC_DIV 3'h7
`define FSPM_STABLE_TICKS 2'h2
`define FSPM_SETTLE_CYCLES 8'hFF

`endif

/* src/fspm_debounce.v */
// Purpose: wake input debouncer on the debounce tick
// Assumes: input already synchronised to ref_clk
// Notes: level output is asserted after the input stays high for a set tick count
`timescale 1ns/1ps
`default_nettype none
`include "fspm_map.vh"
module fspm_debounce (
  input wire ref_clk,
  input wire rst,
  input wire tick,
  input wire din,
  output reg dout
);
  reg [1:0] cnt_q;
  reg last_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      last_q <= 1'b0;
      dout <= 1'b0;
    end else if (tick) begin
      last_q <= din;
      if (din != last_q) begin
        cnt_q <= 2'h0;
      end else if (cnt_q != `FSPM_STABLE_TICKS) begin
        cnt_q <= cnt_q + 2'h1;
      end else begin
        dout <= din;
      end
    end
  end
endmodule
`default_nettype wire

/* src/fspm_power_manager.v */
// Purpose: five state power manager with AHB-Lite register port
// Assumes: single clock ref_clk; wake and interrupt inputs asynchronous
// Notes: analogue oscillator and power switches are driven by enable outputs
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fspm_map.vh"
module fspm_power_manager #(
  parameter NUM_GATES = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rtc_clk_in,
  input wire on_key_n,
  input wire rtc_alarm,
  input wire modem_ring_indicate_in_n,
  input wire cpu_irq,
  input wire cpu_fiq,
  input wire cpu_bus_req,
  input wire bus_grant,
  output reg bus_request,
  output reg cpu_bus_rate_clocking,
  output reg cpu_clk_en,
  output reg internal_clk_en,
  output reg sdram_self_refresh,
  output reg main_osc_en,
  output reg pll_en,
  output reg core_power_en,
  output reg [NUM_GATES-1:0] periph_clk_en,
  output reg [2:0] power_state
);
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_SLOW = 5'h02;
  localparam [4:0] ST_IDLE = 5'h04;
  localparam [4:0] ST_SLEEP = 5'h08;
  localparam [4:0] ST_DEEP = 5'h10;

  // synchronisers for asynchronous pins
  reg [5:0] s1_q;
  reg [5:0] s2_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= {rtc_clk_in, ~on_key_n, rtc_alarm, ~modem_ring_indicate_in_n, cpu_irq, cpu_fiq};
      s2_q <= s1_q;
    end
  end
  wire rtc_s = s2_q[5];
  wire irq_any = s2_q[1] | s2_q[0];

  // debounce tick: RTC clock divided by 8
  reg rtc_last_q;
  reg [2:0] div_q;
  reg tick_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtc_last_q <= 1'b0;
      div_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      rtc_last_q <= rtc_s;
      tick_q <= 1'b0;
      if (rtc_s && !rtc_last_q) begin
        div_q <= div_q + 3'h1;
        tick_q <= (div_q == `FSPM_RTC_DIV);
      end
    end
  end

  // on-key, RTC alarm, modem ring each debounced
  wire [2:0] wake_db;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_wake
      fspm_debounce u_db (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick_q),
        .din(s2_q[gi+2]),
        .dout(wake_db[gi])
      );
    end
  endgenerate
  wire wake_request = |wake_db;

  // register port
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [2:0] mode_req_q;
  reg mode_pend_q;
  reg [NUM_GATES-1:0] gate_q;
  reg ap_write_q;
  reg ap_read_q;
  reg [7:0] ap_addr_q;
  reg ap_valid_q;
  wire ap_take = hsel && hready && htrans[1];
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_write_q <= 1'b0;
      ap_read_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_write_q <= ap_take && hwrite;
      ap_read_q <= ap_take && !hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end
  wire ap_hit = (ap_addr_q == `FSPM_ADDR_MODE) || (ap_addr_q == `FSPM_ADDR_GATE) ||
                (ap_addr_q == `FSPM_ADDR_STAT);

  reg bus_owned_q;
  reg [7:0] settle_q;
  wire idle_req = mode_pend_q && (mode_req_q == `FSPM_MODE_IDLE);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_req_q <= `FSPM_MODE_SLOW;
      mode_pend_q <= 1'b0;
      gate_q <= `FSPM_GATE_RESET;
    end else begin
      if (ap_write_q && ap_addr_q == `FSPM_ADDR_MODE) begin
        mode_req_q <= hwdata[2:0];
        mode_pend_q <= 1'b1;
      end else if (state_q != state_d) begin
        mode_pend_q <= 1'b0;
      end
      if (ap_write_q && ap_addr_q == `FSPM_ADDR_GATE) begin
        gate_q <= hwdata[NUM_GATES-1:0];
      end
    end
  end

  // state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN, ST_SLOW: begin
        if (mode_pend_q) begin
          if (mode_req_q == `FSPM_MODE_IDLE) begin
            state_d = ST_IDLE;
          end else if (mode_req_q == `FSPM_MODE_RUN) begin
            state_d = ST_RUN;
          end else if (mode_req_q == `FSPM_MODE_SLOW) begin
            state_d = ST_SLOW;
          end
        end
      end
      ST_IDLE: begin
        // after standby, stay here until self-refresh has been released
        if (irq_any && !idle_req && (settle_q <= 8'h01)) begin
          state_d = ST_RUN;
        end else if (mode_pend_q && bus_owned_q &&
                     (mode_req_q == `FSPM_MODE_SLEEP || mode_req_q == `FSPM_MODE_DEEP)) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_request) begin
          state_d = ST_IDLE;
        end else if (mode_req_q == `FSPM_MODE_DEEP) begin
          state_d = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (wake_request) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_SLOW;
      end
    endcase
  end

  reg deep_exit_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_SLOW;
      bus_owned_q <= 1'b0;
      settle_q <= 8'h00;
      deep_exit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bus_owned_q <= (state_q == ST_IDLE || state_q == ST_SLEEP || state_q == ST_DEEP) &&
                     bus_grant;
      if (state_q == ST_DEEP && state_d == ST_IDLE) begin
        deep_exit_q <= 1'b1;
      end else if (state_q == ST_RUN) begin
        deep_exit_q <= 1'b0;
      end
      // clocks must settle before SDRAM leaves self-refresh
      if (state_q == ST_SLEEP || state_q == ST_DEEP) begin
        settle_q <= `FSPM_SETTLE_CYCLES;
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
      end
    end
  end

  // outputs, all registered
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_request <= 1'b0;
      cpu_bus_rate_clocking <= 1'b1;
      cpu_clk_en <= 1'b1;
      internal_clk_en <= 1'b1;
      sdram_self_refresh <= 1'b0;
      main_osc_en <= 1'b1;
      pll_en <= 1'b1;
      core_power_en <= 1'b1;
      periph_clk_en <= {NUM_GATES{1'b0}};
      power_state <= `FSPM_MODE_SLOW;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      bus_request <= (state_d != ST_RUN) && (state_d != ST_SLOW);
      // a deep sleep exit keeps bus-rate clocking until the state returns to run
      cpu_bus_rate_clocking <= (state_d == ST_SLOW) ||
                               (deep_exit_q && (state_d != ST_RUN)) ||
                               (state_q == ST_DEEP && state_d == ST_IDLE);
      cpu_clk_en <= !((state_d == ST_IDLE) && cpu_bus_req) &&
                    (state_d == ST_RUN || state_d == ST_SLOW ||
                     (state_d == ST_IDLE && cpu_clk_en));
      internal_clk_en <= (state_d != ST_SLEEP) && (state_d != ST_DEEP);
      sdram_self_refresh <= (state_d == ST_SLEEP) || (state_d == ST_DEEP) ||
                            (settle_q > 8'h01);
      main_osc_en <= (state_d != ST_DEEP);
      pll_en <= (state_d != ST_DEEP);
      core_power_en <= (state_d != ST_DEEP);
      periph_clk_en <= (state_d == ST_RUN || state_d == ST_SLOW) ? gate_q :
                       {NUM_GATES{1'b0}};
      case (state_d)
        ST_RUN: power_state <= `FSPM_MODE_RUN;
        ST_IDLE: power_state <= `FSPM_MODE_IDLE;
        ST_SLEEP: power_state <= `FSPM_MODE_SLEEP;
        ST_DEEP: power_state <= `FSPM_MODE_DEEP;
        default: power_state <= `FSPM_MODE_SLOW;
      endcase
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take && !hwrite) begin
        case (haddr[7:0])
          `FSPM_ADDR_MODE: hrdata <= {29'h0, mode_req_q};
          `FSPM_ADDR_GATE: hrdata <= {{(32-NUM_GATES){1'b0}}, gate_q};
          `FSPM_ADDR_STAT: hrdata <= {26'h0, bus_owned_q, wake_request, 1'b0, power_state};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* dv/fspm_cpu_model.sv */
// Purpose: CPU core and bus arbiter stand-in facing the power manager
// Assumes: grant delay comes from the bench
// Notes: a stalled CPU keeps its access pending
`timescale 1ns/1ps
`default_nettype none
module fspm_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] grant_dly,
  input wire logic bus_request,
  input wire logic cpu_clk_en,
  output logic bus_grant,
  output logic cpu_bus_req
);
  logic [3:0] wait_q;
  logic [1:0] phase_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      phase_q <= 2'h0;
      bus_grant <= 1'b0;
      cpu_bus_req <= 1'b0;
    end else begin
      wait_q <= bus_request ? wait_q + {3'h0, wait_q != grant_dly} : 4'h0;
      bus_grant <= bus_request && wait_q == grant_dly;
      if (cpu_clk_en) begin
        phase_q <= phase_q + 2'h1;
        cpu_bus_req <= phase_q == 2'h3;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/fspm_power_manager_asserts.sv */
// Purpose: temporal checks on the power manager outputs
// Assumes: power_state follows the internal state register in the same cycle
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module fspm_pm_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] power_state,
  input wire logic cpu_irq,
  input wire logic cpu_fiq,
  input wire logic cpu_bus_req,
  input wire logic bus_grant,
  input wire logic bus_request,
  input wire logic cpu_bus_rate_clocking,
  input wire logic cpu_clk_en,
  input wire logic internal_clk_en,
  input wire logic sdram_self_refresh,
  input wire logic main_osc_en,
  input wire logic pll_en,
  input wire logic core_power_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  state_legal_a: assert property (power_state <= 3'h4)
    else $error("state code out of range");
  run_clocks_a: assert property (power_state == 3'h0 |->
    internal_clk_en && !sdram_self_refresh && !cpu_bus_rate_clocking) else $error("run outputs");
  slow_rate_a: assert property (power_state == 3'h1 |-> cpu_bus_rate_clocking)
    else $error("slow without bus rate");
  idle_master_a: assert property ($rose(power_state == 3'h2) |-> ##[0:2] bus_request)
    else $error("idle without bus request");
  idle_halt_a: assert property (power_state == 3'h2 && cpu_bus_req && !cpu_irq
    && !cpu_fiq |-> ##[0:2] !cpu_clk_en) else $error("cpu clock not halted");
  sleep_entry_a: assert property (power_state == 3'h3 && $past(power_state) != 3'h3
    |-> $past(power_state) == 3'h2 && $past(bus_grant, 2)) else $error("bad sleep entry");
  sleep_gate_a: assert property (power_state == 3'h3 |->
    sdram_self_refresh && !internal_clk_en) else $error("sleep outputs");
  deep_off_a: assert property ($rose(power_state == 3'h4) |-> ##[0:3]
    (!main_osc_en && !pll_en && !core_power_en && sdram_self_refresh)) else $error("deep");
  wake_exit_a: assert property (power_state != $past(power_state)
    && $past(power_state) > 3'h2 |-> power_state == 3'h2
    || (power_state == 3'h4 && $past(power_state) == 3'h3)) else $error("bad exit");
  refresh_exit_a: assert property ($fell(sdram_self_refresh) |->
    main_osc_en && pll_en && core_power_en) else $error("refresh left early");
  sleep_seen_c: cover property (power_state == 3'h3);
  deep_seen_c: cover property (power_state == 3'h4);
  idle_exit_c: cover property (power_state == 3'h2 ##1 power_state == 3'h0);
endmodule
bind fspm_power_manager fspm_pm_asserts chk_u (.ref_clk, .rst, .power_state, .cpu_irq,
  .cpu_fiq, .cpu_bus_req, .bus_grant, .bus_request, .cpu_bus_rate_clocking, .cpu_clk_en,
  .internal_clk_en, .sdram_self_refresh, .main_osc_en, .pll_en, .core_power_en);
`default_nettype wire

/* dv/fspm_power_manager_tb.sv */
// Purpose: self-checking bench for the power manager
// Assumes: rtc clock sped up so the wake debounce fits a short run
// Notes: every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module fspm_power_manager_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rtc_clk_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [2:0] wk = 3'h0;
  logic cpu_irq = 1'b0;
  logic cpu_fiq = 1'b0;
  logic [3:0] gdly = 4'h1;
  int errors = 0;
  int check_count = 0;
  wire [31:0] hrdata;
  wire [15:0] periph_clk_en;
  wire [2:0] power_state;
  wire hreadyout, bus_grant, cpu_bus_req, bus_request, cpu_clk_en, sdram_self_refresh;
  wire cpu_bus_rate_clocking, internal_clk_en, main_osc_en, pll_en, core_power_en;
  fspm_power_manager dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .rtc_clk_in,
    .on_key_n(~wk[0]), .rtc_alarm(wk[1]), .modem_ring_indicate_in_n(~wk[2]), .cpu_irq,
    .cpu_fiq, .cpu_bus_req, .bus_grant, .bus_request, .cpu_bus_rate_clocking, .cpu_clk_en,
    .internal_clk_en, .sdram_self_refresh, .main_osc_en, .pll_en, .core_power_en,
    .periph_clk_en, .power_state);
  fspm_cpu_model cpu_u (.ref_clk, .rst, .grant_dly(gdly), .bus_request, .cpu_clk_en,
    .bus_grant, .cpu_bus_req);
  always #5 ref_clk = ~ref_clk;
  always #33 rtc_clk_in = ~rtc_clk_in;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 40);
    rd = hrdata;
    chk({31'h0, n >= 40}, 32'h0);
    if (n >= 40) stop_test();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 3000 && power_state !== s; n++) @(posedge ref_clk);
    chk({29'h0, power_state}, {29'h0, s});
    if (power_state !== s) stop_test();
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({28'h0, cpu_bus_rate_clocking, power_state}, 32'h9);
    rchk(8'h04, 32'hFFFFFFFF, 32'h0000FFFF);
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
    rchk(8'h0C, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, 8'h04, 32'h0000A5C3);
    repeat (2) @(posedge ref_clk);
    chk({16'h0, periph_clk_en}, 32'h0000A5C3);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, 8'h00, m);
      wait_st(m[2:0]);
      chk({31'h0, cpu_bus_rate_clocking}, m);
      rchk(8'h08, 32'h7, m);
    end
    $display("test modes done");
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, 8'h00, 32'h2);
      wait_st(3'h2);
      for (int n = 0; n < 40 && cpu_clk_en !== 1'b0; n++) @(posedge ref_clk);
      chk({30'h0, bus_request, cpu_clk_en}, 32'h2);
      {cpu_fiq, cpu_irq} <= i ? 2'b10 : 2'b01;
      wait_st(3'h0);
      {cpu_fiq, cpu_irq} <= 2'b00;
    end
    $display("test idle done");
    for (int s = 0; s < 3; s++) begin
      gdly <= s ? 4'h9 : 4'h2;
      ahb(1'b1, 8'h04, 32'h0);
      ahb(1'b1, 8'h00, 32'h2);
      wait_st(3'h2);
      for (int n = 0; n < 60 && bus_grant !== 1'b1; n++) @(posedge ref_clk);
      chk({31'h0, bus_grant}, 32'h1);
      ahb(1'b1, 8'h00, s ? 32'h4 : 32'h3);
      wait_st(s ? 3'h4 : 3'h3);
      // a pulse shorter than one debounce tick must not wake
      wk <= 3'h1 << s;
      repeat (20) @(posedge ref_clk);
      wk <= 3'h0;
      repeat (80) @(posedge ref_clk);
      chk({29'h0, power_state}, s ? 32'h4 : 32'h3);
      chk({30'h0, sdram_self_refresh, internal_clk_en}, 32'h2);
      if (s > 0) chk({29'h0, main_osc_en, pll_en, core_power_en}, 32'h0);
      wk <= 3'h1 << s;
      wait_st(3'h2);
      if (s > 0) chk({31'h0, cpu_bus_rate_clocking}, 32'h1);
      wk <= 3'h0;
      cpu_irq <= 1'b1;
      wait_st(3'h0);
      cpu_irq <= 1'b0;
      // let the wake debouncers fall back before the next standby entry
      repeat (300) @(posedge ref_clk);
      chk({28'h0, sdram_self_refresh, main_osc_en, pll_en, core_power_en}, 32'h7);
    end
    $display("test standby done");
    stop_test();
  end
endmodule
`default_nettype wire
